// file: hdl/ccl_pkg.sv
// Package with register map, field positions and carrier types for the comparator control logic
package ccl_pkg;

  // Register word offsets (byte addresses, one word each)
  localparam logic [3:0] CTRL0_C1_OFS  = 4'h0;
  localparam logic [3:0] CTRL1_C1_OFS  = 4'h4;
  localparam logic [3:0] CTRL0_C2_OFS  = 4'h8;
  localparam logic [3:0] CTRL1_C2_OFS  = 4'hc;
  localparam logic [3:0] MIRROR_OFS    = 4'h0 + 4'h0;
  localparam logic [4:0] MIRROR_ADDR   = 5'h10;
  localparam logic [4:0] FLAGS_ADDR    = 5'h14;
  localparam logic [4:0] PORT_ADDR     = 5'h18;
  localparam logic [4:0] ASEL_ADDR     = 5'h1c;

  // Control zero fields
  localparam int EN_BIT     = 7;
  localparam int RES_BIT    = 6;
  localparam int OE_BIT     = 5;
  localparam int POL_BIT    = 4;
  localparam int SP_BIT     = 2;
  localparam int HYS_BIT    = 1;
  localparam int SYNC_BIT   = 0;
  // Control one fields
  localparam int RISE_BIT   = 7;
  localparam int FALL_BIT   = 6;
  localparam int PSEL_LO    = 4;
  localparam int NSEL_LO    = 0;

  // Writable masks and reset values
  localparam logic [7:0] CTRL0_WMASK = 8'hb7;
  localparam logic [7:0] CTRL1_WMASK = 8'hf3;
  localparam logic [7:0] CTRL0_RESET = 8'h04;
  localparam logic [7:0] CTRL1_RESET = 8'h00;
  localparam logic [7:0] ASEL_RESET  = 8'hff;

  // Positive input routing codes
  localparam logic [1:0] PSEL_PIN   = 2'h0;
  localparam logic [1:0] PSEL_DAC   = 2'h1;
  localparam logic [1:0] PSEL_FIXED = 2'h2;
  localparam logic [1:0] PSEL_GND   = 2'h3;

  // Analog-side controls for one comparator
  typedef struct packed {
    logic       power;
    logic       speed;
    logic       hyst;
    logic [3:0] pos_route;
    logic [3:0] neg_route;
  } ccl_analog_t;

endpackage : ccl_pkg

// file: hdl/ccl_top.sv
// Comparator control logic: registers, synchronisers, sync latch, edge flags, pin outputs
`timescale 1ns/1ns
module ccl_top #(
  parameter int PORT_W = 8
) (
  input  wire logic                 clock_in,
  input  wire logic                 rstn_in,
  // Avalon-MM slave
  input  wire logic [4:0]           avs_address_in,
  input  wire logic                 avs_read_in,
  input  wire logic                 avs_write_in,
  input  wire logic [31:0]          avs_writedata_in,
  input  wire logic [3:0]           avs_byteenable_in,
  output logic      [31:0]          avs_readdata_out,
  output logic                      avs_waitrequest_out,
  // Raw analog comparison results, asynchronous
  input  wire logic [1:0]           cmp_raw_in,
  // Prescaled timer clock source, asynchronous
  input  wire logic                 timer_clk_in,
  // Port pin levels and direction bits
  input  wire logic [PORT_W-1:0]    port_pins_in,
  input  wire logic [1:0]           port_direction_in,
  // Analog-side controls
  output ccl_pkg::ccl_analog_t      cmp1_analog_out,
  output ccl_pkg::ccl_analog_t      cmp2_analog_out,
  // Result pins, two-signal form
  output logic [1:0]                cmp_pin_out,
  output logic [1:0]                cmp_pin_oe_n_out,
  // Results toward timer gate and PWM shutdown
  output logic [1:0]                cmp_timer_out,
  output logic [1:0]                cmp_shutdown_out,
  // Sticky interrupt flags
  output logic [1:0]                cmp_irq_flag_out
);

  // Reset release through two flops
  logic [1:0] rst_sync;
  logic       rst_n;
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) rst_sync <= 2'h0;
    else          rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  // Control registers per comparator, plus the shared analog select
  logic [7:0] ctrl0 [2];
  logic [7:0] ctrl1 [2];
  logic [PORT_W-1:0] analog_select;

  // Two-flop synchronisers; first stage read only by second
  logic [1:0] raw_s1, raw_s2, tclk_s1, tclk_s2, tclk_d;
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      raw_s1  <= 2'h0;
      raw_s2  <= 2'h0;
      tclk_s1 <= 2'h0;
      tclk_s2 <= 2'h0;
      tclk_d  <= 2'h0;
    end else begin
      raw_s1  <= cmp_raw_in;
      raw_s2  <= raw_s1;
      tclk_s1 <= {2{timer_clk_in}};
      tclk_s2 <= tclk_s1;
      tclk_d  <= tclk_s2;
    end
  end

  logic [PORT_W-1:0] pin_s1, pin_s2;
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
    end else begin
      pin_s1 <= port_pins_in;
      pin_s2 <= pin_s1;
    end
  end

  // Per-comparator result path
  logic [1:0] result, result_d, sync_res, rise, fall, flag_set, flag_clr;
  logic [1:0] tclk_fall;
  logic [1:0] irq_flag;
  assign tclk_fall = tclk_d & ~tclk_s2;   // Falling edge of prescaled timer clock

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_cmp
      // Disabled core compares as low; polarity still applies, so toggling
      // enable or polarity can make an edge even while off
      assign result[g] = (raw_s2[g] & ctrl0[g][ccl_pkg::EN_BIT])
                         ^ ctrl0[g][ccl_pkg::POL_BIT];
      assign rise[g] = result[g] & ~result_d[g] & ctrl1[g][ccl_pkg::RISE_BIT];
      assign fall[g] = ~result[g] & result_d[g] & ctrl1[g][ccl_pkg::FALL_BIT];
      assign flag_set[g] = rise[g] | fall[g];
    end
  endgenerate

  // Result history and timer-synchronised copy
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      result_d <= 2'h0;
      sync_res <= 2'h0;
    end else begin
      result_d <= result;
      for (int i = 0; i < 2; i++) begin
        if (tclk_fall[i]) sync_res[i] <= result[i];
      end
    end
  end

  // Flags: set wins over a clear in the same cycle
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) irq_flag <= 2'h0;
    else        irq_flag <= flag_set | (irq_flag & ~flag_clr);
  end

  // Delivered result: synced or passed straight through
  logic [1:0] delivered;
  generate
    for (g = 0; g < 2; g++) begin : g_del
      assign delivered[g] = ctrl0[g][ccl_pkg::SYNC_BIT] ? sync_res[g] : result[g];
    end
  endgenerate

  // Decode one-hot routing for an enabled comparator
  function automatic logic [3:0] route(input logic en, input logic [1:0] sel);
    route = en ? (4'h1 << sel) : 4'h0;
  endfunction

  ccl_pkg::ccl_analog_t next_analog [2];
  generate
    for (g = 0; g < 2; g++) begin : g_an
      assign next_analog[g].power = ctrl0[g][ccl_pkg::EN_BIT];
      assign next_analog[g].speed = ctrl0[g][ccl_pkg::SP_BIT];
      assign next_analog[g].hyst  = ctrl0[g][ccl_pkg::HYS_BIT];
      // Positive codes map pin, DAC, fixed reference, ground in order
      assign next_analog[g].pos_route = route(ctrl0[g][ccl_pkg::EN_BIT],
          ctrl1[g][ccl_pkg::PSEL_LO +: 2]);
      assign next_analog[g].neg_route = route(ctrl0[g][ccl_pkg::EN_BIT],
          ctrl1[g][ccl_pkg::NSEL_LO +: 2]);
    end
  endgenerate

  // Registered outputs toward analog, pins, timer and PWM
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      cmp1_analog_out  <= '0;
      cmp2_analog_out  <= '0;
      cmp_pin_out      <= 2'h0;
      cmp_pin_oe_n_out <= 2'h3;
      cmp_timer_out    <= 2'h0;
      cmp_shutdown_out <= 2'h0;
      cmp_irq_flag_out <= 2'h0;
    end else begin
      cmp1_analog_out  <= next_analog[0];
      cmp2_analog_out  <= next_analog[1];
      cmp_pin_out      <= delivered;
      // Pin driven when output enable set and direction is output (low)
      cmp_pin_oe_n_out <= ~({ctrl0[1][ccl_pkg::OE_BIT], ctrl0[0][ccl_pkg::OE_BIT]}
                            & ~port_direction_in);
      cmp_timer_out    <= delivered;
      cmp_shutdown_out <= result;
      cmp_irq_flag_out <= irq_flag;
    end
  end

  // Bus decode
  logic acc, wr;
  logic [7:0] wbyte;
  assign acc   = avs_read_in | avs_write_in;
  assign wr    = avs_write_in & avs_byteenable_in[0] & ~avs_waitrequest_out;
  assign wbyte = avs_writedata_in[7:0];

  logic hit_c0 [2];
  logic hit_c1 [2];
  assign hit_c0[0] = avs_address_in == {1'b0, ccl_pkg::CTRL0_C1_OFS};
  assign hit_c1[0] = avs_address_in == {1'b0, ccl_pkg::CTRL1_C1_OFS};
  assign hit_c0[1] = avs_address_in == {1'b0, ccl_pkg::CTRL0_C2_OFS};
  assign hit_c1[1] = avs_address_in == {1'b0, ccl_pkg::CTRL1_C2_OFS};
  assign flag_clr  = (wr && avs_address_in == ccl_pkg::FLAGS_ADDR) ? wbyte[1:0] : 2'h0;

  // Register writes; unmapped writes are ignored
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      ctrl0[0]      <= ccl_pkg::CTRL0_RESET;
      ctrl0[1]      <= ccl_pkg::CTRL0_RESET;
      ctrl1[0]      <= ccl_pkg::CTRL1_RESET;
      ctrl1[1]      <= ccl_pkg::CTRL1_RESET;
      analog_select <= {PORT_W{1'b1}};
    end else if (wr) begin
      for (int i = 0; i < 2; i++) begin
        if (hit_c0[i]) ctrl0[i] <= wbyte & ccl_pkg::CTRL0_WMASK;
        if (hit_c1[i]) ctrl1[i] <= wbyte & ccl_pkg::CTRL1_WMASK;
      end
      if (avs_address_in == ccl_pkg::ASEL_ADDR) analog_select <= wbyte[PORT_W-1:0];
    end
  end

  // Read mux; result bit overlays live status into control zero
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    unique case (avs_address_in)
      {1'b0, ccl_pkg::CTRL0_C1_OFS}: rd_mux[7:0] = {ctrl0[0][7], result[0], ctrl0[0][5:0]};
      {1'b0, ccl_pkg::CTRL1_C1_OFS}: rd_mux[7:0] = ctrl1[0];
      {1'b0, ccl_pkg::CTRL0_C2_OFS}: rd_mux[7:0] = {ctrl0[1][7], result[1], ctrl0[1][5:0]};
      {1'b0, ccl_pkg::CTRL1_C2_OFS}: rd_mux[7:0] = ctrl1[1];
      ccl_pkg::MIRROR_ADDR:          rd_mux[1:0] = result;
      ccl_pkg::FLAGS_ADDR:           rd_mux[1:0] = irq_flag;
      ccl_pkg::PORT_ADDR:            rd_mux[PORT_W-1:0] = pin_s2 & ~analog_select;
      ccl_pkg::ASEL_ADDR:            rd_mux[PORT_W-1:0] = analog_select;
      default:                       rd_mux = 32'h0;
    endcase
  end

  // One wait cycle per access so read data come from a flop
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out    <= 32'h0;
    end else begin
      avs_waitrequest_out <= ~(acc & avs_waitrequest_out);
      if (avs_read_in & avs_waitrequest_out) avs_readdata_out <= rd_mux;
    end
  end

endmodule : ccl_top

// file: testbench/ccl_partner.sv
// Behavioural pair of analog comparator cores fed by the routing controls
`timescale 1ns/1ns
module ccl_partner (
  input  wire logic                 clock_in,
  input  wire ccl_pkg::ccl_analog_t cfg1_in,
  input  wire ccl_pkg::ccl_analog_t cfg2_in,
  input  wire logic [3:0]           pos_hi_in,
  input  wire logic [3:0]           neg_hi_in,
  output logic      [1:0]           raw_out
);
  logic [1:0] cmp;
  logic [1:0] raw_q = 2'h0;
  // A high source beats a low one; only a high positive over a low negative reads 1
  assign cmp[0] = |(cfg1_in.pos_route & pos_hi_in) & ~|(cfg1_in.neg_route & neg_hi_in);
  assign cmp[1] = |(cfg2_in.pos_route & pos_hi_in) & ~|(cfg2_in.neg_route & neg_hi_in);
  assign raw_out = raw_q;
  // An unpowered core gives no valid level, so it wanders instead of holding
  always @(posedge clock_in) begin
    raw_q[0] <= cfg1_in.power ? cmp[0] : ~raw_q[0];
    raw_q[1] <= cfg2_in.power ? cmp[1] : ~raw_q[1];
  end
endmodule : ccl_partner

// file: testbench/ccl_top_assertions.sv
// Port-level assertions for the comparator control logic
`timescale 1ns/1ns
module ccl_top_assertions (
  input wire logic                 clock_in,
  input wire logic                 rstn_in,
  input wire logic                 avs_read_in,
  input wire logic                 avs_write_in,
  input wire logic [31:0]          avs_readdata_out,
  input wire logic                 avs_waitrequest_out,
  input wire logic [1:0]           port_direction_in,
  input wire ccl_pkg::ccl_analog_t cmp1_analog_out,
  input wire ccl_pkg::ccl_analog_t cmp2_analog_out,
  input wire logic [1:0]           cmp_pin_out,
  input wire logic [1:0]           cmp_pin_oe_n_out,
  input wire logic [1:0]           cmp_timer_out,
  input wire logic [1:0]           cmp_irq_flag_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  // An access is taken while waitrequest is high and answered one cycle later
  sequence taken_s; (avs_read_in || avs_write_in) && avs_waitrequest_out; endsequence
  sequence answer_s; !avs_waitrequest_out ##1 avs_waitrequest_out; endsequence
  AST_ONE_WAIT: assert property (taken_s |=> answer_s)
    else $error("access not answered after one wait cycle");
  AST_NO_SPURIOUS: assert property (!avs_read_in && !avs_write_in && avs_waitrequest_out
    |=> avs_waitrequest_out) else $error("answer without a request");
  AST_RDATA_MOVES: assert property ($changed(avs_readdata_out)
    |-> !avs_waitrequest_out && $past(avs_read_in)) else $error("read data moved outside a read");
  AST_OFF_NO_ROUTE: assert property (!cmp1_analog_out.power |-> cmp1_analog_out.pos_route == 4'h0
    && cmp1_analog_out.neg_route == 4'h0) else $error("disabled comparator one still routed");
  AST_OFF_NO_ROUTE2: assert property (!cmp2_analog_out.power |-> cmp2_analog_out.pos_route == 4'h0
    && cmp2_analog_out.neg_route == 4'h0) else $error("disabled comparator two still routed");
  AST_ROUTE_ONE: assert property (cmp1_analog_out.power |-> $onehot(cmp1_analog_out.pos_route)
    && $onehot(cmp1_analog_out.neg_route)) else $error("routing not a single source");
  AST_PIN_DRIVE: assert property ((~cmp_pin_oe_n_out & $past(port_direction_in)) == 2'h0)
    else $error("pin driven while direction selects input");
  AST_FLAG_CLEAR: assert property ((|($past(cmp_irq_flag_out) & ~cmp_irq_flag_out))
    |-> $past(avs_write_in) || $past(avs_write_in, 2)) else $error("flag fell without a write");
  AST_PIN_TIMER: assert property (cmp_pin_out == cmp_timer_out)
    else $error("pin and timer results differ");
endmodule : ccl_top_assertions
bind ccl_top ccl_top_assertions u_chk (.*);

// file: testbench/ccl_top_test.sv
// Register-level test of the comparator control logic
`timescale 1ns/1ns
module ccl_top_test;
  localparam logic [3:0] PH = 4'h3;  // Pin and DAC high, fixed and ground low
  localparam logic [3:0] NH = 4'h5;  // Negative pins zero and two high
  logic                 clock_in, rstn_in, rd, wr_s, wt, tclk, e;
  logic [4:0]           addr, base;
  logic [31:0]          wdata, rdata, q;
  logic [3:0]           be;
  logic [1:0]           raw, dir, pin, oe_n, tmr, sd, flag;
  logic [7:0]           pins;
  ccl_pkg::ccl_analog_t cfg1, cfg2;
  int                   err_total, checks;

  ccl_top u_dut (.clock_in(clock_in), .rstn_in(rstn_in), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr_s), .avs_writedata_in(wdata),
    .avs_byteenable_in(be), .avs_readdata_out(rdata), .avs_waitrequest_out(wt),
    .cmp_raw_in(raw), .timer_clk_in(tclk), .port_pins_in(pins), .port_direction_in(dir),
    .cmp1_analog_out(cfg1), .cmp2_analog_out(cfg2), .cmp_pin_out(pin),
    .cmp_pin_oe_n_out(oe_n), .cmp_timer_out(tmr), .cmp_shutdown_out(sd),
    .cmp_irq_flag_out(flag));
  ccl_partner u_ana (.clock_in(clock_in), .cfg1_in(cfg1), .cfg2_in(cfg2),
    .pos_hi_in(PH), .neg_hi_in(NH), .raw_out(raw));

  initial begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end

  task automatic summarize();
    if (err_total == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk

  // Holds the request until waitrequest is sampled low, then releases
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
                     input logic [3:0] b);
    int n;
    n = 0;
    addr <= a;
    wdata <= {24'h0, d};
    be <= b;
    rd <= ~w;
    wr_s <= w;
    do begin
      @(posedge clock_in);
      n++;
    end while (wt !== 1'b0 && n < 20);
    q = rdata;
    rd <= 1'b0;
    wr_s <= 1'b0;
    // Only a request still unanswered counts as a timeout
    if (wt !== 1'b0) begin
      err_total++;
      summarize();
    end
    @(posedge clock_in);
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'h1);
  endtask : wr

  task automatic rchk(input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 8'h00, 4'h0);
    chk(q, exp);
  endtask : rchk

  task automatic idle(input int n);
    repeat (n) @(posedge clock_in);
  endtask : idle

  // Main sequence
  initial begin
    {rstn_in, rd, wr_s, addr, wdata, be} = '0;
    {err_total, checks} = '0;
    dir = 2'h3;
    tclk = 1'b1;
    pins = 8'ha5;
    idle(4);
    rstn_in <= 1'b1;
    idle(3);
    rchk(5'h00, 32'h04);
    rchk(5'h04, 32'h00);
    rchk(5'h10, 32'h00);
    rchk(5'h18, 32'h00);
    bus(1'b1, 5'h04, 8'hff, 4'he);
    rchk(5'h04, 32'h00);
    wr(5'h04, 8'hff);
    rchk(5'h04, 32'hf3);
    wr(5'h1c, 8'h0f);
    rchk(5'h18, {24'h0, pins & 8'hf0});
    for (int c = 0; c < 2; c++) begin
      base = 5'(8 * c);
      wr(base, 8'h82);
      for (int k = 0; k < 16; k++) begin
        wr(base + 5'h04, {2'h0, 2'(k >> 2), 2'h0, 2'(k)});
        idle(6);
        e = PH[k >> 2] & ~NH[k & 3];
        chk({21'h0, c ? cfg2 : cfg1}, {21'h0, 3'h5, 4'h1 << (k >> 2), 4'h1 << (k & 3)});
        rchk(base, {24'h0, 1'b1, e, 6'h02});
        rchk(5'h10, {30'h0, 2'(e) << c});
        chk({30'h0, sd}, {30'h0, 2'(e) << c});
      end
      wr(base + 5'h04, 8'h00);
      wr(base, 8'h92);
      idle(6);
      rchk(base, 32'hd2);
      wr(base, 8'h00);
      idle(2);
      chk({21'h0, c ? cfg2 : cfg1}, 32'h0);
      wr(5'h14, 8'h03);
      for (int s = 0; s < 4; s++) begin
        wr(base + 5'h04, s < 2 ? 8'h80 : 8'h40);
        wr(base, s[0] ? 8'h00 : 8'h10);
        idle(6);
        chk({30'h0, flag}, {30'h0, 2'(s == 0 || s == 3) << c});
        wr(5'h14, 8'h03);
      end
      wr(base, 8'h30);
      idle(6);
      chk({28'h0, oe_n, pin}, {28'h0, 2'h3, 2'h1 << c});
      dir <= 2'h0;
      idle(3);
      chk({30'h0, oe_n}, {30'h0, ~(2'h1 << c)});
      // Sync on before the next timer fall: pin and timer hold the old latched low
      wr(base, 8'h31);
      idle(6);
      chk({26'h0, sd, pin, tmr}, {26'h0, 2'h1 << c, 4'h0});
      tclk <= 1'b0;
      idle(6);
      chk({26'h0, sd, pin, tmr}, {26'h0, 2'h1 << c, 2'h1 << c, 2'h1 << c});
      tclk <= 1'b1;
      wr(base, 8'h21);
      idle(6);
      chk({26'h0, sd, pin, tmr}, {26'h0, 2'h0, 2'h1 << c, 2'h1 << c});
      tclk <= 1'b0;
      idle(6);
      chk({28'h0, pin, tmr}, 32'h0);
      tclk <= 1'b1;
      wr(base, 8'h00);
      dir <= 2'h3;
    end
    summarize();
  end
endmodule : ccl_top_test
